// ### pswf_regs.svh
/*
  Offsets, field positions, reset values and codes of the power status
  and wakeup flag block. Assumes inclusion by bare name from the package;
  the design files use its macros without including it themselves.
*/
`ifndef PSWF_REGS_SVH
`define PSWF_REGS_SVH
`define PSWF_OFS_CTRL   8'h00
`define PSWF_OFS_STAT   8'h04
`define PSWF_CTRL_RST   32'h0000_0000
`define PSWF_STAT_RST   32'h0000_0000
`define PSWF_LDR_HI     19
`define PSWF_LDR_LO     18
`define PSWF_VSEL_BIT   14
`define PSWF_WEN_HI     11
`define PSWF_WEN_LO     8
`define PSWF_LVF_BIT    2
`define PSWF_STB_BIT    1
`define PSWF_WAK_BIT    0
`define PSWF_LDS_HI     19
`define PSWF_LDS_LO     18
`define PSWF_LVE_BIT    4
`define PSWF_SCLR_BIT   3
`define PSWF_WCLR_BIT   2
`define PSWF_LD_ON      2'h3
`define PSWF_LD_OFF     2'h0
`define PSWF_NPINS      4
`define PSWF_NRTC       4
`endif

// ### pswf_pkg.sv
/*
  Types shared by the power status and wakeup flag modules.
  Assumes pswf_regs.svh is on the include path.
*/
package pswf_pkg;
`include "pswf_regs.svh"
    typedef enum logic [1:0] {
        mode_run   = 2'b00,
        mode_deep  = 2'b01,
        mode_stby  = 2'b10
    } pswf_mode_type;

    typedef struct packed {
        pswf_mode_type               mode;
        logic [1:0]                  ld_select;
        logic                        lvd_enable;
        logic [1:0]                  ld_ready;
        logic                        vsel_ready;
        logic [`PSWF_NPINS-1:0]      wake_en;
        logic                        standby_seen;
        logic                        wake_seen;
        logic [31:0]                 rdata;
    } pswf_top_state_type;

    typedef struct packed {
        logic [`PSWF_NPINS-1:0]      pin_prev;
        logic [`PSWF_NPINS-1:0]      en_prev;
        logic                        req;
    } pswf_wake_state_type;

    typedef struct packed {
        logic                        flag;
    } pswf_lvd_state_type;
endpackage

// ### pswf_core_if.sv
/*
  Carrier between the top and its wake detector and voltage monitor.
  Assumes the package has been compiled first.
*/
interface pswf_core_if;
    logic [3:0] pin;
    logic [3:0] en;
    logic [3:0] rtc;
    logic       req;
    logic       det_out;
    logic       lvd_en;
    logic       standby;
    logic       lvd_flag;
    modport core (output pin, en, rtc, det_out, lvd_en, standby,
                  input  req, lvd_flag);
    modport wake (input  pin, en, rtc, output req);
    modport lvd  (input  det_out, lvd_en, standby, output lvd_flag);
endinterface

// ### pswf_wake_detect.sv
/*
  Wakeup detector: per pin rising edge and level-on-enable events, merged
  with the clock-domain events into one registered request.
  Assumes pin and event inputs are synchronous to ref_clk_i.
*/
module pswf_wake_detect
    import pswf_pkg::*;
(
    input  wire logic   ref_clk_i,
    input  wire logic   srst_i,
    pswf_core_if.wake   bus
);
    pswf_wake_state_type q, d;
    logic [`PSWF_NPINS-1:0] hit;

    // -----------------------------------------------------------------
    // Per pin events
    // -----------------------------------------------------------------
    for (genvar i = 0; i < `PSWF_NPINS; i++) begin : g_pin
        assign hit[i] = bus.en[i] & bus.pin[i] &
                        (~q.pin_prev[i] | ~q.en_prev[i]);
    end

    always_comb begin
        d          = q;
        d.pin_prev = bus.pin;
        d.en_prev  = bus.en;
        d.req      = (|hit) | (|bus.rtc);
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.req = q.req;
endmodule // pswf_wake_detect

// ### pswf_lvd_track.sv
/*
  Low-voltage flag tracker: follows the detector output while enabled
  and freezes it in standby. Assumes detector output is synchronous.
*/
module pswf_lvd_track
    import pswf_pkg::*;
(
    input  wire logic   ref_clk_i,
    input  wire logic   srst_i,
    pswf_core_if.lvd    bus
);
    pswf_lvd_state_type q, d;

    always_comb begin
        d = q;
        if (!bus.standby) begin
            d.flag = bus.lvd_en & bus.det_out;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.lvd_flag = q.flag;
endmodule // pswf_lvd_track

// ### pswf_top.sv
/*
  Power status and wakeup flag block: control word at the first offset,
  status and wakeup enable word at the second, mode tracking for flag
  setting, and the wake detector and voltage monitor beneath it.
  Assumes srst_i is the power-on / power-down reset, that stby_wake_rst_i
  pulses on a wakeup from standby, and that all inputs are synchronous.
*/
module pswf_top
    import pswf_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        stby_wake_rst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        deep_sleep_i,
    input  wire logic        standby_i,
    input  wire logic        vsel_ready_i,
    input  wire logic        lvd_out_i,
    input  wire logic [3:0]  wake_pin_i,
    input  wire logic [3:0]  rtc_wake_i,
    output logic             wake_req_o,
    output logic             low_driver_req_o,
    output logic             lvd_enable_o
);
    import pswf_pkg::*;

    // -----------------------------------------------------------------
    // State and decode
    // -----------------------------------------------------------------
    pswf_top_state_type q, d;
    pswf_core_if        core ();

    logic        wr_ctrl;
    logic        wr_stat;
    logic        rd_ctrl;
    logic        rd_stat;
    logic        clr_standby;
    logic        clr_wake;
    logic        clr_ldr;
    logic        deep_entry;
    logic        ld_mode_on;
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;

    assign wr_ctrl = reg_we_i & (reg_addr_i == `PSWF_OFS_CTRL);
    assign wr_stat = reg_we_i & (reg_addr_i == `PSWF_OFS_STAT);
    assign rd_ctrl = reg_re_i & (reg_addr_i == `PSWF_OFS_CTRL);
    assign rd_stat = reg_re_i & (reg_addr_i == `PSWF_OFS_STAT);

    // Clear strobes act only on a written 1; a 0 leaves flags alone
    assign clr_standby = wr_ctrl & reg_wdata_i[`PSWF_SCLR_BIT];
    assign clr_wake    = wr_ctrl & reg_wdata_i[`PSWF_WCLR_BIT];
    assign clr_ldr     = wr_stat &
        (reg_wdata_i[`PSWF_LDR_HI:`PSWF_LDR_LO] == `PSWF_LD_ON);

    // Reserved codes 01 and 10 never count as low-driver mode
    assign ld_mode_on  = (q.ld_select == `PSWF_LD_ON);
    assign deep_entry  = (q.mode == mode_run) & deep_sleep_i & ~standby_i;

    // -----------------------------------------------------------------
    // Sub-block wiring
    // -----------------------------------------------------------------
    assign core.pin     = wake_pin_i;
    assign core.en      = q.wake_en;
    assign core.rtc     = rtc_wake_i;
    assign core.det_out = lvd_out_i;
    assign core.lvd_en  = q.lvd_enable;
    assign core.standby = (q.mode == mode_stby) | standby_i;

    pswf_wake_detect u_wake (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .bus       (core.wake)
    );

    pswf_lvd_track u_lvd (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .bus       (core.lvd)
    );

    // -----------------------------------------------------------------
    // Read views
    // -----------------------------------------------------------------
    always_comb begin
        ctrl_view = '0;
        ctrl_view[`PSWF_LDS_HI:`PSWF_LDS_LO] = q.ld_select;
        ctrl_view[`PSWF_LVE_BIT] = q.lvd_enable;
        // Clear bits are strobes and always read as zero
        ctrl_view[`PSWF_SCLR_BIT] = 1'b0;
        ctrl_view[`PSWF_WCLR_BIT] = 1'b0;
    end

    always_comb begin
        stat_view = `PSWF_STAT_RST;
        stat_view[`PSWF_LDR_HI:`PSWF_LDR_LO] = q.ld_ready;
        stat_view[`PSWF_VSEL_BIT] = q.vsel_ready;
        stat_view[`PSWF_WEN_HI:`PSWF_WEN_LO] = q.wake_en;
        stat_view[`PSWF_LVF_BIT] = core.lvd_flag;
        stat_view[`PSWF_STB_BIT] = q.standby_seen;
        stat_view[`PSWF_WAK_BIT] = q.wake_seen;
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        d = q;

        // Power mode tracking, used to catch deep-sleep entries and to hold the low-voltage flag in standby
        case (q.mode)
            mode_run: begin
                if (standby_i) begin
                    d.mode = mode_stby;
                end else if (deep_sleep_i) begin
                    d.mode = mode_deep;
                end
            end
            mode_deep: begin
                if (standby_i) begin
                    d.mode = mode_stby;
                end else if (!deep_sleep_i) begin
                    d.mode = mode_run;
                end
            end
            mode_stby: begin
                if (!standby_i) begin
                    d.mode = mode_run;
                end
            end
            default: begin
                d.mode = mode_run;
            end
        endcase

        // Control word
        if (wr_ctrl) begin
            d.ld_select  = reg_wdata_i[`PSWF_LDS_HI:`PSWF_LDS_LO];
            d.lvd_enable = reg_wdata_i[`PSWF_LVE_BIT];
        end

        // Wake pin enables take the written data; writing 11 to the low-driver ready field clears it
        if (wr_stat) begin
            d.wake_en = reg_wdata_i[`PSWF_WEN_HI:`PSWF_WEN_LO];
        end

        // Low-driver ready: a new deep-sleep entry beats a clear
        if (clr_ldr) begin
            d.ld_ready = `PSWF_LD_OFF;
        end
        if (deep_entry && ld_mode_on) begin
            d.ld_ready = `PSWF_LD_ON;
        end

        d.vsel_ready = vsel_ready_i;

        // Standby flag: set wins over a same-cycle clear
        if (clr_standby) begin
            d.standby_seen = 1'b0;
        end
        if (standby_i) begin
            d.standby_seen = 1'b1;
        end

        // Wake flag: set wins over a same-cycle clear
        if (clr_wake) begin
            d.wake_seen = 1'b0;
        end
        if (core.req) begin
            d.wake_seen = 1'b1;
        end

        // Read data stand for exactly one cycle after the strobe
        if (rd_ctrl) begin
            d.rdata = ctrl_view;
        end else if (rd_stat) begin
            d.rdata = stat_view;
        end else begin
            // Unmapped or idle: zero
            d.rdata = '0;
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    // The standby-wake reset hits only the control word, so the status
    // word keeps its enables and all flags but the low-voltage flag, which clears once lvd_enable is dropped.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q            <= '0;
            q.mode       <= mode_run;
            q.ld_select  <= `PSWF_LD_OFF;
        end else if (stby_wake_rst_i) begin
            q            <= d;
            q.ld_select  <= `PSWF_LD_OFF;
            q.lvd_enable <= 1'b0;
        end else begin
            q            <= d;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign reg_rdata_o      = q.rdata;
    assign wake_req_o       = core.req;
    assign low_driver_req_o = ld_mode_on;
    assign lvd_enable_o     = q.lvd_enable;
endmodule // pswf_top

// ### pswf_top_properties.sv
/*
  Checker for the power status and wakeup flag block: ties read data,
  flags and requests to their causes. Assumes binding to pswf_top.
*/
module pswf_top_properties (
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    input wire logic        stby_wake_rst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_we_i,
    input wire logic        reg_re_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        deep_sleep_i,
    input wire logic        standby_i,
    input wire logic [3:0]  wake_pin_i,
    input wire logic [3:0]  rtc_wake_i,
    input wire logic        wake_req_o,
    input wire logic        low_driver_req_o
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence rd_stat_s;
        reg_re_i && reg_addr_i == 8'h04;
    endsequence
    sequence rd_ctrl_s;
        reg_re_i && reg_addr_i == 8'h00;
    endsequence
    // Entry into deep-sleep with low-driver mode selected
    sequence ld_arm_s;
        $rose(deep_sleep_i) && low_driver_req_o;
    endsequence
    // No deep-sleep entry alongside, as a set would win
    sequence ld_clr_s;
        reg_we_i && reg_addr_i == 8'h04 && reg_wdata_i[19:18] == 2'h3
            && !deep_sleep_i;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    ldr_set_a: assert property (
        ld_arm_s ##1 rd_stat_s |=> reg_rdata_o[19:18] == 2'h3)
        else $error("low driver ready not set");
    ldr_clear_a: assert property (
        ld_clr_s ##1 rd_stat_s |=> reg_rdata_o[19:18] == 2'h0)
        else $error("low driver ready not cleared");
    stby_flag_a: assert property (
        standby_i ##1 rd_stat_s |=> reg_rdata_o[1])
        else $error("standby flag not set");
    rtc_wake_a: assert property (
        rtc_wake_i != 4'h0 |=> wake_req_o)
        else $error("clock event gave no wake request");
    wake_cause_a: assert property (
        wake_req_o |-> $past(wake_pin_i) != 4'h0
            || $past(rtc_wake_i) != 4'h0)
        else $error("wake request without cause");
    wake_flag_a: assert property (
        wake_req_o ##1 rd_stat_s |=> reg_rdata_o[0])
        else $error("wake flag not set");
    clear_bits_a: assert property (
        rd_ctrl_s |=> reg_rdata_o[3:2] == 2'h0)
        else $error("clear bits read back set");
    reserved_zero_a: assert property (
        rd_stat_s |=> (reg_rdata_o & 32'hfff3_b0f8) == 32'h0)
        else $error("reserved status bits set");
    ld_select_a: assert property (
        reg_we_i && reg_addr_i == 8'h00 && !stby_wake_rst_i |=>
        low_driver_req_o == ($past(reg_wdata_i[19:18]) == 2'h3))
        else $error("low driver request wrong");
endmodule // pswf_top_properties

bind pswf_top pswf_top_properties u_props (
    .ref_clk_i, .srst_i, .stby_wake_rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .deep_sleep_i, .standby_i,
    .wake_pin_i, .rtc_wake_i, .wake_req_o, .low_driver_req_o
);

// ### tb_power_status_wakeup_flags.sv
/*
  Self-checking bench for the power status and wakeup flag block.
  Assumes the package, interface, design and checker compiled first.
*/
module tb_power_status_wakeup_flags;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        wrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic        deep = 1'b0;
    logic        stby = 1'b0;
    logic        vsel = 1'b0;
    logic        lvd = 1'b0;
    logic [3:0]  pin = 4'h0;
    logic [3:0]  rtc = 4'h0;
    logic [31:0] rdata;
    logic        wake_req;
    logic        ld_req;
    logic        lvd_en;
    logic [31:0] e_m;
    logic [31:0] rnd = 32'h3e5d53b9;
    logic [3:0]  en = 4'h0;
    logic        re_d = 1'b0;
    logic [31:0] exp_q[$];
    int          error_cnt = 0;
    int          compares = 0;

    always #20 clk = ~clk;

    pswf_top u_dut (
        .ref_clk_i(clk), .srst_i(srst), .stby_wake_rst_i(wrst),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
        .reg_re_i(re), .reg_rdata_o(rdata), .deep_sleep_i(deep),
        .standby_i(stby), .vsel_ready_i(vsel), .lvd_out_i(lvd),
        .wake_pin_i(pin), .rtc_wake_i(rtc), .wake_req_o(wake_req),
        .low_driver_req_o(ld_req), .lvd_enable_o(lvd_en)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] st(input logic [1:0] l,
                                       input logic f, s, w);
        return {12'h0, l, 3'h0, vsel, 2'h0, en, 5'h0, f, s, w};
    endfunction
    // The write strobe is dropped by whatever follows a write, so that
    // back-to-back strobes never assign we twice in one step
    task automatic tick(input int n);
        we <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wd   <= d;
        we   <= 1'b1;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        we   <= 1'b0;
        re   <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
    endtask
    // Direct look at a level output that stands between edges
    task automatic chk(input string n, input logic e, input logic s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        re_d <= re;
        if (re_d) begin
            e_m = exp_q.pop_front();
            compares++;
            if (rdata !== e_m) begin
                error_cnt++;
                $display("unexpected reg_rdata_o: expected %h, seen %h",
                         e_m, rdata);
            end
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        tick(20);
        srst <= 1'b0;
        tick(2);
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        rnd = lfsr(rnd);
        wr(8'h08, rnd);
        rd(8'h08, 32'h0);
        rnd = lfsr(rnd);
        en = 4'hf;
        wr(8'h04, rnd | 32'h0000_0f00);
        rd(8'h04, st(2'h0, 0, 0, 0));
        vsel <= 1'b1;
        tick(1);
        rd(8'h04, st(2'h0, 0, 0, 0));
        wr(8'h00, 32'h000c_0000);
        deep <= 1'b1;
        tick(1);
        chk("low_driver_req_o", 1'b1, ld_req);
        rd(8'h04, st(2'h3, 0, 0, 0));
        deep <= 1'b0;
        wr(8'h04, st(2'h3, 0, 0, 0));
        rd(8'h04, st(2'h0, 0, 0, 0));
        wr(8'h00, 32'h0004_0000);
        deep <= 1'b1;
        tick(1);
        chk("low_driver_req_o", 1'b0, ld_req);
        rd(8'h04, st(2'h0, 0, 0, 0));
        deep <= 1'b0;
        en = 4'h1;
        wr(8'h04, 32'h0000_0100);
        pin <= 4'h2;
        tick(3);
        rd(8'h04, st(2'h0, 0, 0, 0));
        pin <= 4'h3;
        tick(2);
        rd(8'h04, st(2'h0, 0, 0, 1));
        wr(8'h00, 32'h0000_0004);
        rd(8'h04, st(2'h0, 0, 0, 0));
        pin <= 4'h7;
        tick(2);
        en = 4'h5;
        wr(8'h04, 32'h0000_0500);
        tick(2);
        rd(8'h04, st(2'h0, 0, 0, 1));
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h0000_0004);
            rtc <= 4'h1 << i;
            tick(1);
            rtc <= 4'h0;
            tick(1);
            chk("wake_req_o", 1'b1, wake_req);
            rd(8'h04, st(2'h0, 0, 0, 1));
            chk("wake_req_o", 1'b0, wake_req);
        end
        wr(8'h00, 32'h0000_0014);
        lvd <= 1'b1;
        tick(2);
        chk("lvd_enable_o", 1'b1, lvd_en);
        rd(8'h04, st(2'h0, 1, 0, 0));
        // Detector halted: the flag must hold while supply recovers
        stby <= 1'b1;
        lvd  <= 1'b0;
        tick(2);
        rd(8'h04, st(2'h0, 1, 1, 0));
        stby <= 1'b0;
        tick(2);
        rd(8'h04, st(2'h0, 0, 1, 0));
        wrst <= 1'b1;
        tick(1);
        wrst <= 1'b0;
        rd(8'h00, 32'h0);
        chk("lvd_enable_o", 1'b0, lvd_en);
        rd(8'h04, st(2'h0, 0, 1, 0));
        wr(8'h00, 32'h0000_0008);
        rd(8'h04, st(2'h0, 0, 0, 0));
        rd(8'h00, 32'h0);
        tick(2);
        conclude();
    end
endmodule // tb_power_status_wakeup_flags
